// ---- logic/fiv_pkg.sv ----
package fiv_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_F0_SEL = 8'h09;
	localparam logic [7:0] IDX_F0_LOW = 8'h0a;
	localparam logic [7:0] IDX_F0_HIGH = 8'h0b;
	localparam logic [7:0] IDX_F1_SEL = 8'h0c;
	localparam logic [7:0] IDX_F1_LOW = 8'h0d;
	localparam logic [7:0] IDX_F1_HIGH = 8'h0e;
	localparam logic [7:0] IDX_PEND0 = 8'h0f;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h15;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h16;
	// Field layout
	localparam int SEL_W = 7;
	localparam int LOW_W = 16;
	localparam int HIGH_W = 5;
	localparam int VAB_W = 21;
	localparam int PEND_FIRST = 2;
	localparam int PEND_LAST = 16;
	localparam int EVT_W = 2;
	localparam int EVT_FAST0 = 0;
	localparam int EVT_FAST1 = 1;
	// Reset values
	localparam logic [SEL_W-1:0] SEL_RST = 7'h00;
	localparam logic [LOW_W-1:0] LOW_RST = 16'h0000;
	localparam logic [HIGH_W-1:0] HIGH_RST = 5'h00;
	localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
	localparam logic [VAB_W-1:0] VAB_RST = 21'h000000;
	localparam logic PEND_BIT0 = 1'b1;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// One fast vector: selection and direct address
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [HIGH_W-1:0] high;
		logic [LOW_W-1:0] low;
	} fiv_fast_type;

	// Answer presented to the core
	typedef struct packed {
		logic valid;
		logic fast0;
		logic fast1;
		logic [VAB_W-1:0] vab;
	} fiv_vec_type;

	// Latched AHB address phase
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] idx;
	} fiv_aphase_type;
endpackage

// ---- logic/fiv_vectoring.sv ----
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
// Contract
// - Fast 0 vector is 5-bit high field above 16-bit low field, 21 bits.
// - Fast 1 holds a 16-bit low address field in bits 15..0.
// - Fast 1 holds a 5-bit high field in bits 4..0 above the low field.
// - A 7-bit field, bits 6..0, names the fast 1 vector number.
// - Exactly two requests are fast, one per selection field.
// - A taken fast interrupt vectors straight to its own address fields.
// - A fast request beats every other level 2 request.
// - With both fast requests active, fast 0 goes first.
// - Unused selection bits 15..7 and high bits 15..5 read zero.
// - Pending word bits 1..15 report vector numbers 2..16.
// - Pending bits read 0 while pending, 1 when not.
// - Pending word bit 0 always reads one.
// - A 7-bit field, bits 6..0, names the fast 0 vector number.
// - Fast 0 holds a 16-bit low address field in bits 15..0.
module fiv_vectoring
	import fiv_pkg::*;
#(
	parameter int NUM_VEC = 67
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Requests and level 2 winner from the arbiter
	input wire logic [NUM_VEC-1:0] irq_req,
	input wire logic norm_valid,
	input wire logic [VAB_W-1:0] norm_vab,
	input wire logic core_ack,
	// To the core
	output logic core_irq,
	output logic core_fast0,
	output logic core_fast1,
	output logic [VAB_W-1:0] core_vab,
	// Interrupt
	output logic irq
);

	// Selection hits only a real request line
	function automatic logic fast_hit(input logic [SEL_W-1:0] sel,
		input logic [NUM_VEC-1:0] req);
		logic hit;
		hit = 1'b0;
		if (int'(sel) >= PEND_FIRST && int'(sel) < NUM_VEC) begin
			hit = req[sel];
		end
		return hit;
	endfunction

	function automatic logic [31:0] wide16(input logic [15:0] v);
		return {16'h0000, v};
	endfunction

	fiv_fast_type f0_reg, f0_next, f1_reg, f1_next;
	fiv_vec_type vec_reg, vec_next;
	fiv_aphase_type ap_reg, ap_next;
	logic [EVT_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic hreadyout_reg, irq_reg;

	// Address phase decode
	wire a_take = hsel & hready & htrans[1];
	wire [7:0] a_idx = haddr[9:2];
	wire a_in_range = (haddr[31:10] == 22'h000000);
	assign ap_next.wr = a_take & hwrite & a_in_range;
	assign ap_next.rd = a_take & ~hwrite & a_in_range;
	assign ap_next.idx = a_idx;

	// Data phase writes
	wire d_wr = ap_reg.wr;
	wire w_f0_sel = d_wr & (ap_reg.idx == IDX_F0_SEL);
	wire w_f0_low = d_wr & (ap_reg.idx == IDX_F0_LOW);
	wire w_f0_high = d_wr & (ap_reg.idx == IDX_F0_HIGH);
	wire w_f1_sel = d_wr & (ap_reg.idx == IDX_F1_SEL);
	wire w_f1_low = d_wr & (ap_reg.idx == IDX_F1_LOW);
	wire w_f1_high = d_wr & (ap_reg.idx == IDX_F1_HIGH);
	wire w_stat = d_wr & (ap_reg.idx == IDX_IRQ_STAT);
	wire w_mask = d_wr & (ap_reg.idx == IDX_IRQ_MASK);

	assign f0_next.sel = w_f0_sel ? hwdata[SEL_W-1:0] : f0_reg.sel;
	assign f0_next.low = w_f0_low ? hwdata[LOW_W-1:0] : f0_reg.low;
	assign f0_next.high = w_f0_high ? hwdata[HIGH_W-1:0] : f0_reg.high;
	assign f1_next.sel = w_f1_sel ? hwdata[SEL_W-1:0] : f1_reg.sel;
	assign f1_next.low = w_f1_low ? hwdata[LOW_W-1:0] : f1_reg.low;
	assign f1_next.high = w_f1_high ? hwdata[HIGH_W-1:0] : f1_reg.high;
	assign mask_next = w_mask ? hwdata[EVT_W-1:0] : mask_reg;

	// Fast selection and priority
	wire hit0 = fast_hit(f0_reg.sel, irq_req);
	wire hit1 = fast_hit(f1_reg.sel, irq_req);
	wire [VAB_W-1:0] vab0 = {f0_reg.high, f0_reg.low};
	wire [VAB_W-1:0] vab1 = {f1_reg.high, f1_reg.low};
	// Fast 0 ahead of fast 1, both ahead of the normal level 2 winner
	assign vec_next.fast0 = hit0;
	assign vec_next.fast1 = hit1 & ~hit0;
	assign vec_next.valid = hit0 | hit1 | norm_valid;
	assign vec_next.vab = hit0 ? vab0 :
		hit1 ? vab1 :
		norm_valid ? norm_vab : VAB_RST;

	// Events: core takes a fast vector; set wins over clear
	wire [EVT_W-1:0] evt = {core_ack & vec_reg.valid & vec_reg.fast1,
		core_ack & vec_reg.valid & vec_reg.fast0};
	wire [EVT_W-1:0] clr = w_stat ? hwdata[EVT_W-1:0] : EVT_RST;
	assign stat_next = (stat_reg & ~clr) | evt;

	// Pending word is live; bits above the word read zero
	wire [15:0] pend0 = {~irq_req[PEND_LAST:PEND_FIRST], PEND_BIT0};

	// Read mux uses next values so a read right after a write sees it
	wire [7:0] r_idx = a_idx;
	wire r_en = ap_next.rd;
	logic [15:0] r_val;
	always_comb begin
		r_val = 16'h0000;
		case (r_idx)
		IDX_F0_SEL: r_val = {9'h000, f0_next.sel};
		IDX_F0_LOW: r_val = f0_next.low;
		IDX_F0_HIGH: r_val = {11'h000, f0_next.high};
		IDX_F1_SEL: r_val = {9'h000, f1_next.sel};
		IDX_F1_LOW: r_val = f1_next.low;
		IDX_F1_HIGH: r_val = {11'h000, f1_next.high};
		IDX_PEND0: r_val = pend0;
		IDX_IRQ_STAT: r_val = {14'h0000, stat_next};
		IDX_IRQ_MASK: r_val = {14'h0000, mask_next};
		default: r_val = 16'h0000;
		endcase
	end
	assign hrdata_next = r_en ? wide16(r_val) : 32'h00000000;

	// Selection and address fields
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			f0_reg <= '{sel: SEL_RST, high: HIGH_RST, low: LOW_RST};
			f1_reg <= '{sel: SEL_RST, high: HIGH_RST, low: LOW_RST};
		end else begin
			f0_reg <= f0_next;
			f1_reg <= f1_next;
		end
	end

	// Bus slave state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ap_reg <= '{wr: 1'b0, rd: 1'b0, idx: 8'h00};
			hrdata_reg <= 32'h00000000;
			hreadyout_reg <= 1'b0;
		end else begin
			ap_reg <= ap_next;
			hrdata_reg <= hrdata_next;
			hreadyout_reg <= 1'b1;
		end
	end

	// Core answer and interrupt
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vec_reg <= '{valid: 1'b0, fast0: 1'b0, fast1: 1'b0, vab: VAB_RST};
			stat_reg <= EVT_RST;
			mask_reg <= EVT_RST;
			irq_reg <= 1'b0;
		end else begin
			vec_reg <= vec_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			irq_reg <= |(stat_next & mask_next);
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_reg;
	assign core_irq = vec_reg.valid;
	assign core_fast0 = vec_reg.fast0;
	assign core_fast1 = vec_reg.fast1;
	assign core_vab = vec_reg.vab;
	assign irq = irq_reg;

	// Checks
	a_fast0_vab: assert property (@(posedge clk) disable iff (!rstn)
		hit0 |=> core_fast0 && core_vab == $past(vab0))
		else $error("fast 0 vector address wrong");
	a_fast1_vab: assert property (@(posedge clk) disable iff (!rstn)
		hit1 && !hit0 |=> core_fast1 && core_vab == $past(vab1))
		else $error("fast 1 vector address wrong");
	a_fast_order: assert property (@(posedge clk) disable iff (!rstn)
		hit0 && hit1 |=> core_fast0 && !core_fast1)
		else $error("fast 1 served ahead of fast 0");
	a_fast_over_norm: assert property (@(posedge clk)
		disable iff (!rstn)
		(hit0 || hit1) && norm_valid |=> (core_fast0 || core_fast1)
			&& core_vab == $past(hit0 ? vab0 : vab1))
		else $error("normal vector beat a fast request");
	a_pend_bit0: assert property (@(posedge clk) disable iff (!rstn)
		r_en && r_idx == IDX_PEND0 |=> hrdata[0] && hrdata[31:16] == 16'h0)
		else $error("pending bit 0 not one");
	a_pend_low: assert property (@(posedge clk) disable iff (!rstn)
		r_en && r_idx == IDX_PEND0 |=>
			hrdata[15:1] == ~$past(irq_req[PEND_LAST:PEND_FIRST]))
		else $error("pending bits not active low");
	a_sel_upper_zero: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && (r_idx == IDX_F0_SEL || r_idx == IDX_F1_SEL)
			|=> hrdata[31:7] == 25'h0)
		else $error("selection upper bits not zero");
	a_high_upper_zero: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && (r_idx == IDX_F0_HIGH || r_idx == IDX_F1_HIGH)
			|=> hrdata[31:5] == 27'h0)
		else $error("address high upper bits not zero");
	a_write_f0_sel: assert property (@(posedge clk) disable iff (!rstn)
		w_f0_sel |=> f0_reg.sel == $past(hwdata[SEL_W-1:0]))
		else $error("fast 0 selection not written");
	a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
		(evt & mask_next) != EVT_RST |=> irq)
		else $error("interrupt not raised for masked-in event");

	// Field writes land and other fields hold
	a_write_f0_low: assert property (@(posedge clk)
		disable iff (!rstn)
		w_f0_low |=> f0_reg.low == $past(hwdata[LOW_W-1:0]))
		else $error("fast 0 low address not written");
	a_write_f0_high: assert property (@(posedge clk)
		disable iff (!rstn)
		w_f0_high |=> f0_reg.high == $past(hwdata[HIGH_W-1:0]))
		else $error("fast 0 high address not written");
	a_write_f1_sel: assert property (@(posedge clk)
		disable iff (!rstn)
		w_f1_sel |=> f1_reg.sel == $past(hwdata[SEL_W-1:0]))
		else $error("fast 1 selection not written");
	a_write_f1_low: assert property (@(posedge clk)
		disable iff (!rstn)
		w_f1_low |=> f1_reg.low == $past(hwdata[LOW_W-1:0]))
		else $error("fast 1 low address not written");
	a_write_f1_high: assert property (@(posedge clk)
		disable iff (!rstn)
		w_f1_high |=> f1_reg.high == $past(hwdata[HIGH_W-1:0]))
		else $error("fast 1 high address not written");
	a_hold_f0: assert property (@(posedge clk)
		disable iff (!rstn)
		!w_f0_sel && !w_f0_low && !w_f0_high |=> $stable(f0_reg))
		else $error("fast 0 fields changed without a write");
	a_hold_f1: assert property (@(posedge clk)
		disable iff (!rstn)
		!w_f1_sel && !w_f1_low && !w_f1_high |=> $stable(f1_reg))
		else $error("fast 1 fields changed without a write");

	// Read-back of each field; low fields also check upper bits zero
	a_rd_f0_sel: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx == IDX_F0_SEL |=> hrdata[6:0] == $past(f0_next.sel))
		else $error("fast 0 selection read wrong");
	a_rd_f0_low: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx == IDX_F0_LOW |=> hrdata == wide16($past(f0_next.low)))
		else $error("fast 0 low address read wrong");
	a_rd_f0_high: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx == IDX_F0_HIGH |=> hrdata[4:0] == $past(f0_next.high))
		else $error("fast 0 high address read wrong");
	a_rd_f1_sel: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx == IDX_F1_SEL |=> hrdata[6:0] == $past(f1_next.sel))
		else $error("fast 1 selection read wrong");
	a_rd_f1_low: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx == IDX_F1_LOW |=> hrdata == wide16($past(f1_next.low)))
		else $error("fast 1 low address read wrong");
	a_rd_f1_high: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx == IDX_F1_HIGH |=> hrdata[4:0] == $past(f1_next.high))
		else $error("fast 1 high address read wrong");

	// Core answer follows the inputs of the previous edge
	a_norm_path: assert property (@(posedge clk)
		disable iff (!rstn)
		!hit0 && !hit1 && norm_valid |=> core_irq && !core_fast0
			&& !core_fast1 && core_vab == $past(norm_vab))
		else $error("normal vector not presented");
	a_idle_quiet: assert property (@(posedge clk)
		disable iff (!rstn)
		!hit0 && !hit1 && !norm_valid |=> !core_irq && core_vab == VAB_RST)
		else $error("vector presented with no request");
	a_fast_excl: assert property (@(posedge clk)
		disable iff (!rstn)
		core_fast0 |-> !core_fast1)
		else $error("both fast flags set");
	a_fast_valid: assert property (@(posedge clk)
		disable iff (!rstn)
		core_fast0 || core_fast1 |-> core_irq)
		else $error("fast flag without interrupt");
	a_fast0_req: assert property (@(posedge clk)
		disable iff (!rstn)
		core_fast0 |-> $past(irq_req[f0_reg.sel])
			&& int'($past(f0_reg.sel)) >= PEND_FIRST)
		else $error("fast 0 flagged without its request");
	a_fast1_req: assert property (@(posedge clk)
		disable iff (!rstn)
		core_fast1 |-> $past(irq_req[f1_reg.sel] && !hit0))
		else $error("fast 1 flagged without its request");

	// Pending word stays read-only and live
	a_pend_wr_ign: assert property (@(posedge clk)
		disable iff (!rstn)
		d_wr && ap_reg.idx == IDX_PEND0 |=> $stable(f0_reg)
			&& $stable(f1_reg) && $stable(mask_reg))
		else $error("write to pending word changed state");
	a_pend_ends: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx == IDX_PEND0 |=> hrdata[1] == !$past(irq_req[PEND_FIRST])
			&& hrdata[15] == !$past(irq_req[PEND_LAST]))
		else $error("pending word bit order wrong");

	// Bus slave: no wait states, data only in the data phase
	a_no_wait: assert property (@(posedge clk)
		disable iff (!rstn)
		$past(rstn) |-> hreadyout && hresp == HRESP_OKAY)
		else $error("slave not ready or not okay");
	a_rd_idle_zero: assert property (@(posedge clk)
		disable iff (!rstn)
		!r_en |=> hrdata == 32'h00000000)
		else $error("read data outside data phase");
	a_unmapped_zero: assert property (@(posedge clk)
		disable iff (!rstn)
		r_en && r_idx > IDX_IRQ_MASK |=> hrdata == 32'h00000000)
		else $error("unmapped register read not zero");
	a_out_of_range: assert property (@(posedge clk)
		disable iff (!rstn)
		a_take && !a_in_range |=> !ap_reg.wr && !ap_reg.rd)
		else $error("out of range address taken");

	// Status is sticky; a clear never hides a new event
	a_stat_set: assert property (@(posedge clk)
		disable iff (!rstn)
		evt != EVT_RST |=> (stat_reg & $past(evt)) == $past(evt))
		else $error("taken event not recorded");
	a_stat_clear: assert property (@(posedge clk)
		disable iff (!rstn)
		w_stat && evt == EVT_RST |=>
			stat_reg == ($past(stat_reg) & ~$past(hwdata[EVT_W-1:0])))
		else $error("status clear wrong");
	a_irq_low: assert property (@(posedge clk)
		disable iff (!rstn)
		(stat_next & mask_next) == EVT_RST |=> !irq)
		else $error("interrupt high with nothing unmasked");
	a_mask_write: assert property (@(posedge clk)
		disable iff (!rstn)
		w_mask |=> mask_reg == $past(hwdata[EVT_W-1:0]))
		else $error("mask not written");
endmodule

// ---- test/fiv_core_model.sv ----
`timescale 1ns/1ns
module fiv_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// From the block and bench
	input wire logic core_irq,
	input wire logic en,
	input wire logic slow,
	// To the block
	output logic core_ack
);
	logic [1:0] wait_reg;
	logic take;
	assign take = en & core_irq & ~core_ack;
	// Slow core stalls three cycles before taking a vector
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_reg <= 2'h0;
			core_ack <= 1'b0;
		end else begin
			core_ack <= take & (~slow | (wait_reg == 2'h3));
			wait_reg <= take ? wait_reg + 2'h1 : 2'h0;
		end
	end
endmodule

// ---- test/test_fast_interrupt_vectoring.sv ----
`timescale 1ns/1ns
module test_fast_interrupt_vectoring
	import fiv_pkg::*;
;
	logic clk, rstn, hsel, hwrite, hreadyout, hresp, nv, ack, en, slow;
	logic core_irq, f0, f1, irq;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [66:0] req;
	logic [VAB_W-1:0] nvab, vab;
	int n_mismatch, cmp_count;
	fiv_vectoring u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .irq_req(req), .norm_valid(nv), .norm_vab(nvab),
		.core_ack(ack), .core_irq(core_irq), .core_fast0(f0),
		.core_fast1(f1), .core_vab(vab), .irq(irq));
	fiv_core_model u_core (.clk(clk), .rstn(rstn), .core_irq(core_irq),
		.en(en), .slow(slow), .core_ack(ack));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task results;
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", s, e, g);
			n_mismatch++;
		end
	endtask
	task wrdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				n_mismatch++;
				results();
			end
			@(posedge clk);
		end
	endtask
	// Single word transfer; read data taken at the data phase edge
	task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {22'h0, i, 2'h0};
		hwrite <= w;
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wrdy();
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task rdc(input logic [7:0] i, input logic [31:0] e);
		xfer(1'b0, i, 32'h0);
		chk($sformatf("reg %h", i), e, q);
	endtask
	task t_reset;
		for (int i = 9; i < 15; i++) rdc(i[7:0], 32'h0);
		rdc(IDX_PEND0, 32'hffff);
	endtask
	task t_fields;
		logic [31:0] e[6];
		e = '{32'h7f, 32'hffff, 32'h1f, 32'h7f, 32'hffff, 32'h1f};
		for (int i = 0; i < 6; i++) xfer(1'b1, 8'h09 + i[7:0], 32'hffffffff);
		for (int i = 0; i < 6; i++) rdc(8'h09 + i[7:0], e[i]);
		xfer(1'b1, IDX_PEND0, 32'h0);
		rdc(IDX_PEND0, 32'hffff);
		xfer(1'b1, 8'h20, 32'hffff);
		rdc(8'h20, 32'h0);
	endtask
	task t_pend;
		@(posedge clk);
		req[16:2] <= 15'h5555;
		repeat (2) @(posedge clk);
		rdc(IDX_PEND0, {16'h0, ~req[16:2], 1'b1});
		req <= '0;
	endtask
	task core_chk(input logic [66:0] r, input logic [23:0] e);
		@(posedge clk);
		req <= r;
		repeat (3) @(posedge clk);
		chk("core", {8'h0, e}, {8'h0, core_irq, f0, f1, vab});
	endtask
	task t_fast;
		// Vectors 5 and 9 are assumed set to priority 2 by software
		xfer(1'b1, IDX_F0_SEL, 32'h5);
		xfer(1'b1, IDX_F0_LOW, 32'h1234);
		xfer(1'b1, IDX_F0_HIGH, 32'h15);
		xfer(1'b1, IDX_F1_SEL, 32'h9);
		xfer(1'b1, IDX_F1_LOW, 32'habcd);
		xfer(1'b1, IDX_F1_HIGH, 32'h0a);
		nv <= 1'b1;
		nvab <= 21'h1f0f0;
		core_chk('0, {3'h4, 21'h1f0f0});
		core_chk(67'h200, {3'h5, 5'h0a, 16'habcd});
		core_chk(67'h220, {3'h6, 5'h15, 16'h1234});
		nv <= 1'b0;
		core_chk('0, 24'h0);
	endtask
	task t_irq;
		xfer(1'b1, IDX_IRQ_MASK, 32'h1);
		en <= 1'b1;
		core_chk(67'h20, {3'h6, 5'h15, 16'h1234});
		// Ack lands one edge later, then status and irq one more
		@(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		rdc(IDX_IRQ_STAT, 32'h1);
		en <= 1'b0;
		req <= '0;
		xfer(1'b1, IDX_IRQ_STAT, 32'h1);
		rdc(IDX_IRQ_STAT, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		slow <= 1'b1;
		en <= 1'b1;
		core_chk(67'h200, {3'h5, 5'h0a, 16'habcd});
		repeat (8) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		rdc(IDX_IRQ_STAT, 32'h2);
		en <= 1'b0;
	endtask
	initial begin
		{rstn, hsel, hwrite, nv, en, slow, htrans} = '0;
		{haddr, hwdata, req, nvab, n_mismatch, cmp_count} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_fields();
		t_pend();
		t_fast();
		t_irq();
		results();
	end
endmodule
